// ### t1_ctrl_defs.vh
// Shared constants for the T1 framer pin-level control block
`ifndef T1_CTRL_DEFS_VH
`define T1_CTRL_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Clock rates in kHz
`define SYS_CLK_KHZ 40000
`define LINE_CLK_KHZ 1544
`define SERIAL_CLK_KHZ 2048

// Line clock recovery oscillator
`define NCO_WIDTH 16
// Phase step for 1.544 MHz at a 40 MHz clock, rounded down
`define NCO_INC 16'h09e1
`define NCO_ALIGN 16'h4000

////////////////////////////////////////////////////////////////////////////////
// Line frame: 193 bits per frame
`define LINE_FRAME_BITS 8'hc1
`define LINE_FRAME_LAST 8'hc0
`define LINE_FRAME_HALF 8'h61

////////////////////////////////////////////////////////////////////////////////
// System side serial frame: 32 slots of 8 bits
`define SLOTS_PER_FRAME 6'h20
`define BITS_PER_SLOT 4'h8
`define CHANNELS 5'h18
`define MASTER1_SLOT 5'h00
`define MASTER2_SLOT 5'h10

// Master word bit positions
`define MCW1_AUX_BIT 3
`define MSW2_AUX_BIT 5

`endif

// ### ctrl_word_ram.v
// Small memory for per-channel control words, registered read data
module ctrl_word_ram (
  // Clock
  input wire clk_in,
  // Write port
  input wire wr_en_in,
  input wire [4:0] wr_addr_in,
  input wire [15:0] wr_data_in,
  // Read port
  input wire [4:0] rd_addr_in,
  output reg [15:0] rd_data_out
);

  reg [15:0] mem [0:23];

  // Write and registered read
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end

endmodule

// ### line_recovery.v
// Line clock recovery and bipolar to unipolar conversion
`include "t1_ctrl_defs.vh"

module line_recovery (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Bipolar line
  input wire line_tip_in,
  input wire line_ring_in,
  // Recovered clock and data
  output reg rclk_out,
  output reg bit_tick_out,
  output reg pos_out,
  output reg neg_out
);

  reg tip;
  reg ring;
  reg mark_prev;
  reg [`NCO_WIDTH-1:0] phase;
  wire mark;
  wire mark_rise;
  wire [`NCO_WIDTH-1:0] next_phase;

  assign mark = tip | ring;
  assign mark_rise = mark & ~mark_prev;
  assign next_phase = phase + `NCO_INC;

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator near 1.544 MHz, pulled into phase on every mark
  always @(posedge clk_in) begin
    if (reset_in) begin
      tip <= 1'b0;
      ring <= 1'b0;
      mark_prev <= 1'b0;
      phase <= {`NCO_WIDTH{1'b0}};
      rclk_out <= 1'b0;
      bit_tick_out <= 1'b0;
      pos_out <= 1'b0;
      neg_out <= 1'b0;
    end else begin
      tip <= line_tip_in;
      ring <= line_ring_in;
      mark_prev <= mark;
      if (mark_rise) begin
        phase <= `NCO_ALIGN;
      end else begin
        phase <= next_phase;
      end
      rclk_out <= phase[`NCO_WIDTH-1];
      bit_tick_out <= ~phase[`NCO_WIDTH-1] & next_phase[`NCO_WIDTH-1] & ~mark_rise;
      // Capture both rails mid-pulse on the recovered clock rise
      if (~phase[`NCO_WIDTH-1] & next_phase[`NCO_WIDTH-1] & ~mark_rise) begin
        pos_out <= tip;
        neg_out <= ring;
      end
    end
  end

endmodule

// ### t1_framer_control_pins.v
// Top of the T1 framer pin-level control block
//
// How it works
// - Recover 1.544 MHz clock from line pulses, output it, capture line data.
// - Split bipolar receive signal into positive and negative unipolar outputs.
// - Frame-rate output divides recovered clock by 193, aligned to line frame.
// - In digital loopback the frame-rate output runs from the transmit clock.
// - Auxiliary output follows bit 3 of master control word 1, primary stream.
// - Auxiliary output updates once per frame from latest received value.
// - Auxiliary status input sampled per frame, reported in master status 2 bit 5.
// - Primary control stream carries 24 channel words and two master words.
// - Secondary control stream carries 24 channel words only.
// - Status stream returns the 24 primary channel words, master word 2 in slot 0 and master status 2 in slot 16.
// - Serial streams sampled on serial clock fall, driven on its rise.
`include "t1_ctrl_defs.vh"

module t1_framer_control_pins (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Line receive side
  input wire line_tip_in,
  input wire line_ring_in,
  input wire line_frame_sync_in,
  output wire recovered_line_clock_out,
  output wire recv_unipolar_pos_out,
  output wire recv_unipolar_neg_out,
  output reg frame_rate_clock_out,
  // Loopback
  input wire digital_loopback_in,
  input wire transmit_line_clock_in,
  // System serial side
  input wire system_serial_clock_in,
  input wire system_frame_pulse_n_in,
  input wire ctrl_stream_in_primary_in,
  input wire ctrl_stream_in_secondary_in,
  output reg status_stream_out,
  // Auxiliary pins
  input wire aux_status_input_in,
  output reg aux_output_pin_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Slot decode: slots 1-3, 5-7, ... carry channels 0..23
  function [5:0] slot_channel;
    input [4:0] slot;
    begin
      if (slot[1:0] == 2'b00) begin
        slot_channel = 6'h00;
      end else begin
        slot_channel = {1'b1, slot - {2'b00, slot[4:2]} - 5'h01};
      end
    end
  endfunction

  // Master slot decode: bit 1 for master word 2, bit 0 for master word 1
  function [1:0] master_sel;
    input [4:0] slot;
    begin
      master_sel = 2'b00;
      if (slot == `MASTER1_SLOT) begin
        master_sel[0] = 1'b1;
      end
      if (slot == `MASTER2_SLOT) begin
        master_sel[1] = 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Line recovery
  wire rclk;
  wire bit_tick;
  wire pos;
  wire neg;

  line_recovery u_line (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .line_tip_in(line_tip_in),
    .line_ring_in(line_ring_in),
    .rclk_out(rclk),
    .bit_tick_out(bit_tick),
    .pos_out(pos),
    .neg_out(neg)
  );

  // Recovery outputs are flip-flops inside the line module
  assign recovered_line_clock_out = rclk;
  assign recv_unipolar_pos_out = pos;
  assign recv_unipolar_neg_out = neg;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame-rate divider
  reg [7:0] line_bit_cnt;
  reg tx_clk_prev;
  wire tx_clk_rise;
  wire div_tick;

  assign tx_clk_rise = transmit_line_clock_in & ~tx_clk_prev;
  assign div_tick = digital_loopback_in ? tx_clk_rise : bit_tick;

  // Transmit clock edge detect for loopback
  always @(posedge clk_in) begin
    if (reset_in) begin
      tx_clk_prev <= 1'b0;
    end else begin
      tx_clk_prev <= transmit_line_clock_in;
    end
  end

  // Count 193 bits; resync to the line frame in normal mode
  // The sync pin is ignored in loopback, where the count follows the local clock
  always @(posedge clk_in) begin
    if (reset_in) begin
      line_bit_cnt <= 8'h00;
      frame_rate_clock_out <= 1'b0;
    end else begin
      if (div_tick) begin
        if (~digital_loopback_in & line_frame_sync_in) begin
          line_bit_cnt <= 8'h00;
        end else if (line_bit_cnt == `LINE_FRAME_LAST) begin
          line_bit_cnt <= 8'h00;
        end else begin
          line_bit_cnt <= line_bit_cnt + 8'h01;
        end
      end
      frame_rate_clock_out <= (line_bit_cnt < `LINE_FRAME_HALF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial clock edges
  reg sclk_meta;
  reg sclk;
  reg sclk_prev;
  wire sclk_fall;
  wire sclk_rise;

  assign sclk_fall = sclk_prev & ~sclk;
  assign sclk_rise = ~sclk_prev & sclk;

  // Two sampling stages; edges come only from the settled second stage
  always @(posedge clk_in) begin
    if (reset_in) begin
      sclk_meta <= 1'b0;
      sclk <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      sclk_meta <= system_serial_clock_in;
      sclk <= sclk_meta;
      sclk_prev <= sclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive shifters and slot counter
  reg [7:0] bit_cnt;
  reg frame_start;
  reg word_done;
  reg [4:0] done_slot;
  wire [4:0] slot;
  wire take_bit;
  wire [1:0] stream_bit;
  wire [15:0] stream_word;
  wire [7:0] word_pri;
  wire [7:0] word_sec;

  assign slot = bit_cnt[7:3];
  assign take_bit = sclk_fall & system_frame_pulse_n_in;
  // Index 1 is the primary stream, index 0 the secondary
  assign stream_bit = {ctrl_stream_in_primary_in, ctrl_stream_in_secondary_in};
  assign word_pri = stream_word[15:8];
  assign word_sec = stream_word[7:0];

  // One shifter per control stream; the word is latched on its eighth bit
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_stream
      reg [6:0] shift;
      reg [7:0] word;
      always @(posedge clk_in) begin
        if (reset_in) begin
          shift <= 7'h00;
          word <= 8'h00;
        end else if (take_bit) begin
          shift <= {shift[5:0], stream_bit[g]};
          if (bit_cnt[2:0] == 3'h7) begin
            word <= {shift, stream_bit[g]};
          end
        end
      end
      assign stream_word[8*g+7:8*g] = word;
    end
  endgenerate

  // Sample on the serial clock fall; frame pulse restarts the count
  always @(posedge clk_in) begin
    if (reset_in) begin
      bit_cnt <= 8'h00;
      frame_start <= 1'b0;
      word_done <= 1'b0;
      done_slot <= 5'h00;
    end else begin
      frame_start <= 1'b0;
      word_done <= 1'b0;
      if (sclk_fall) begin
        if (~system_frame_pulse_n_in) begin
          bit_cnt <= 8'h00;
          frame_start <= 1'b1;
        end else begin
          bit_cnt <= bit_cnt + 8'h01;
          if (bit_cnt[2:0] == 3'h7) begin
            word_done <= 1'b1;
            done_slot <= slot;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control word storage
  reg [7:0] mcw1;
  reg [7:0] mcw2;
  wire [5:0] wr_dec;
  wire [5:0] rd_dec;
  wire [15:0] rd_word;
  wire [1:0] wr_master;
  wire [1:0] rd_master;

  assign wr_dec = slot_channel(done_slot);
  assign rd_dec = slot_channel(slot);
  assign wr_master = master_sel(done_slot);
  assign rd_master = master_sel(slot);

  // Both streams' channel words are written together
  ctrl_word_ram u_ram (
    .clk_in(clk_in),
    .wr_en_in(word_done & wr_dec[5]),
    .wr_addr_in(wr_dec[4:0]),
    .wr_data_in({word_pri, word_sec}),
    .rd_addr_in(rd_dec[4:0]),
    .rd_data_out(rd_word)
  );

  // Master words arrive on the primary stream only
  always @(posedge clk_in) begin
    if (reset_in) begin
      mcw1 <= 8'h00;
      mcw2 <= 8'h00;
    end else if (word_done) begin
      if (wr_master[0]) begin
        mcw1 <= word_pri;
      end
      if (wr_master[1]) begin
        mcw2 <= word_pri;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Once-per-frame auxiliary pin update and status sampling
  reg aux_status;

  always @(posedge clk_in) begin
    if (reset_in) begin
      aux_output_pin_out <= 1'b0;
      aux_status <= 1'b0;
    end else if (frame_start) begin
      aux_output_pin_out <= mcw1[`MCW1_AUX_BIT];
      aux_status <= aux_status_input_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status stream word select
  reg [7:0] status_word;

  always @* begin
    if (rd_dec[5]) begin
      status_word = rd_word[15:8];
    end else if (rd_master[0]) begin
      status_word = mcw2;
    end else if (rd_master[1]) begin
      status_word = 8'h00;
      status_word[`MSW2_AUX_BIT] = aux_status;
    end else begin
      status_word = 8'h00;
    end
  end

  // Drive on the serial clock rise, most significant bit first
  always @(posedge clk_in) begin
    if (reset_in) begin
      status_stream_out <= 1'b0;
    end else if (sclk_rise) begin
      status_stream_out <= status_word[3'h7 - bit_cnt[2:0]];
    end
  end

endmodule

// ### t1_pins_props.sv
// Checker on the top-level pins of the T1 framer control block
module t1_pins_props (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Line side
  input wire logic recovered_line_clock_out,
  input wire logic recv_unipolar_pos_out,
  input wire logic recv_unipolar_neg_out,
  input wire logic frame_rate_clock_out,
  input wire logic digital_loopback_in,
  input wire logic transmit_line_clock_in,
  // Serial side and auxiliary pins
  input wire logic system_serial_clock_in,
  input wire logic system_frame_pulse_n_in,
  input wire logic status_stream_out,
  input wire logic aux_output_pin_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic [7:0] rr, tr, sr, fp;
  logic [3:0] up;
  wire rc = recovered_line_clock_out;
  wire fr = frame_rate_clock_out;
  wire lb = digital_loopback_in;
  ////////////////////////////////////////////////////////////
  // Recent edge history, and a settle count after reset
  always_ff @(posedge clk_in) begin
    rr <= {rr[6:0], $rose(rc)};
    tr <= {tr[6:0], $rose(transmit_line_clock_in)};
    sr <= {sr[6:0], $rose(system_serial_clock_in)};
    fp <= {fp[6:0], !system_frame_pulse_n_in};
    up <= reset_in ? 4'h0 : {up[2:0], 1'h1};
  end
  // A recovered clock rise close by, before or after
  sequence s_near;
    (|rr) or (##[0:4] $rose(rc));
  endsequence
  property p_rclk_gap;
    $rose(rc) |=> !$rose(rc) [*6];
  endproperty
  a_rclk_gap: assert property (p_rclk_gap)
    else $error("recovered clock edges too close");
  property p_rclk_run;
    $rose(rc) |-> ##[1:40] $rose(rc);
  endproperty
  a_rclk_run: assert property (p_rclk_run)
    else $error("recovered clock stalled");
  property p_rail;
    up[3] && ($changed(recv_unipolar_pos_out) || $changed(recv_unipolar_neg_out)) |-> s_near;
  endproperty
  a_rail: assert property (p_rail)
    else $error("rail output moved away from a bit tick");
  property p_frc_line;
    up[3] && $changed(fr) && !lb && !$past(lb, 8) |-> s_near;
  endproperty
  a_frc_line: assert property (p_frc_line)
    else $error("frame rate output moved away from a bit tick");
  property p_frc_loop;
    up[3] && $changed(fr) && lb && $past(lb, 8) |-> |tr;
  endproperty
  a_frc_loop: assert property (p_frc_loop)
    else $error("frame rate output moved without a transmit clock rise");
  property p_stat_rise;
    up[3] && $changed(status_stream_out) |-> |sr;
  endproperty
  a_stat_rise: assert property (p_stat_rise)
    else $error("status stream moved without a serial clock rise");
  property p_aux_frame;
    up[3] && $changed(aux_output_pin_out) |-> |fp;
  endproperty
  a_aux_frame: assert property (p_aux_frame)
    else $error("auxiliary output moved outside a frame start");
  property p_reset;
    disable iff (1'b0)
    reset_in |=> !aux_output_pin_out && !status_stream_out && !fr && !rc
      && !recv_unipolar_pos_out && !recv_unipolar_neg_out;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
endmodule

bind t1_framer_control_pins t1_pins_props chk_u (.clk_in, .reset_in,
  .recovered_line_clock_out, .recv_unipolar_pos_out, .recv_unipolar_neg_out,
  .frame_rate_clock_out, .digital_loopback_in, .transmit_line_clock_in,
  .system_serial_clock_in, .system_frame_pulse_n_in, .status_stream_out,
  .aux_output_pin_out);

// ### sys_ctrl_model.sv
// Model of the system controller on the serial control and status streams
module sys_ctrl_model (
  // Serial clock and frame
  output logic sclk_out,
  output logic fp_n_out,
  // Streams
  output logic pri_out,
  output logic sec_out,
  input wire logic stat_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pri [32];
  logic [7:0] sec [32];
  logic [7:0] stat [32];
  int frames = 0;
  ////////////////////////////////////////////////////////////
  // Frame pulse, then 256 bits sent MSB first per slot
  initial begin
    foreach (pri[i]) begin
      pri[i] = 8'h00;
      sec[i] = 8'h00;
    end
    sclk_out = 0;
    fp_n_out = 1;
    pri_out = 0;
    sec_out = 0;
    forever begin
      #244 sclk_out = 1;
      fp_n_out = 0;
      #244 sclk_out = 0;
      for (int b = 0; b < 256; b++) begin
        #244 sclk_out = 1;
        fp_n_out = 1;
        pri_out = pri[b / 8][7 - b % 8];
        sec_out = sec[b / 8][7 - b % 8];
        #244 sclk_out = 0;
        stat[b / 8][7 - b % 8] = stat_in;
      end
      frames++;
    end
  end
endmodule

// ### tb.sv
// Self-checking bench for the T1 framer control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, reset_in = 1, tip = 0, ring = 0, lb = 0, txc = 0, xs = 0, fs = 0;
  logic use_tip = 0, use_ring = 0;
  wire rclk, pos, neg, frc, sclk, fp_n, p0, p1, st, aux;
  int err_count = 0, cmp_count = 0, ph = 0, n;
  typedef struct {logic [7:0] m1; logic x; logic [7:0] w; logic a; logic [7:0] s16;} row_t;
  row_t rows [3] = '{'{8'h08, 1, 8'h3c, 1, 8'h20}, '{8'hf7, 0, 8'h00, 0, 8'h00},
    '{8'hff, 1, 8'hc3, 1, 8'h20}};
  logic [3:0] lrow [3] = '{4'b1010, 4'b0101, 4'b0000};
  initial forever #12.5 clk_in = ~clk_in;
  // Line pulses and transmit clock, 26 cycles a bit
  always @(negedge clk_in) begin
    ph <= (ph == 25) ? 0 : ph + 1;
    txc <= ph < 13;
    tip <= use_tip && ph < 13;
    ring <= use_ring && ph < 13;
  end
  t1_framer_control_pins dut_u (.clk_in(clk_in), .reset_in(reset_in), .line_tip_in(tip),
    .line_ring_in(ring), .line_frame_sync_in(fs), .recovered_line_clock_out(rclk),
    .recv_unipolar_pos_out(pos), .recv_unipolar_neg_out(neg), .frame_rate_clock_out(frc),
    .digital_loopback_in(lb), .transmit_line_clock_in(txc),
    .system_serial_clock_in(sclk), .system_frame_pulse_n_in(fp_n),
    .ctrl_stream_in_primary_in(p0), .ctrl_stream_in_secondary_in(p1),
    .status_stream_out(st), .aux_status_input_in(xs), .aux_output_pin_out(aux));
  sys_ctrl_model ctl_u (.sclk_out(sclk), .fp_n_out(fp_n), .pri_out(p0), .sec_out(p1),
    .stat_in(st));
  ////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wait_frames(input int nf);
    int f0, k;
    f0 = ctl_u.frames;
    for (k = 0; k < 6000 * nf && ctl_u.frames < f0 + nf; k++)
      @(negedge clk_in);
    if (k == 6000 * nf) begin
      err_count++;
      finish_test();
    end
  endtask
  // Count source rises between the 2nd and 3rd frame-rate rises
  task period(input logic l, output int cnt);
    int k, fc;
    logic s, s0, f, f0;
    lb = l;
    cnt = 0;
    fc = 0;
    for (k = 0; k < 20000 && fc < 3; k++) begin
      @(negedge clk_in);
      s = l ? txc : rclk;
      f = frc;
      if (f && !f0)
        fc++;
      if (fc == 2 && s && !s0)
        cnt++;
      s0 = s;
      f0 = f;
    end
    if (fc < 3) begin
      err_count++;
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] e;
    repeat (5) @(negedge clk_in);
    reset_in = 0;
    foreach (rows[i]) begin
      ctl_u.pri[0] = rows[i].m1;
      ctl_u.pri[16] = rows[i].w ^ 8'h5a;
      xs = rows[i].x;
      for (int s = 1; s < 32; s++) begin
        ctl_u.sec[s] = ~rows[i].w;
        if (s % 4)
          ctl_u.pri[s] = rows[i].w + s;
      end
      wait_frames(3);
      chk("aux_out", rows[i].a, aux);
      for (int s = 0; s < 32; s++) begin
        e = (s % 4) ? rows[i].w + s : 8'h00;
        if (s == 0)
          e = rows[i].w ^ 8'h5a;
        if (s == 16)
          e = rows[i].s16;
        chk("status_slot", e, ctl_u.stat[s]);
      end
      $display("stream row %0d done", i);
    end
    foreach (lrow[i]) begin
      use_tip = lrow[i][3];
      use_ring = lrow[i][2];
      repeat (208) @(negedge clk_in);
      chk("rail_pos", lrow[i][1], pos);
      chk("rail_neg", lrow[i][0], neg);
      $display("line row %0d done", i);
    end
    use_tip = 1;
    period(0, n);
    chk("line_div", 193, n);
    period(1, n);
    chk("loop_div", 193, n);
    lb = 0;
    $display("divider test done");
    // Sync held for one bit; the divider then counts from that bit
    @(negedge clk_in);
    fs = 1;
    repeat (26) @(negedge clk_in);
    fs = 0;
    repeat (94 * 26) @(negedge clk_in);
    chk("sync_high", 1, frc);
    repeat (4 * 26) @(negedge clk_in);
    chk("sync_low", 0, frc);
    $display("sync test done");
    reset_in = 1;
    repeat (2) @(negedge clk_in);
    chk("aux_reset", 0, aux);
    chk("status_reset", 0, st);
    reset_in = 0;
    wait_frames(3);
    chk("aux_after_reset", rows[2].a, aux);
    $display("reset test done");
    finish_test();
  end
endmodule
